// File: hw/usb_ep_csr_defines.svh
// Offsets, field positions, reset values and timing counts of the endpoint CSR block
`ifndef USB_EP_CSR_DEFINES_SVH
`define USB_EP_CSR_DEFINES_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_EP0_OPTION 5'h00
`define OFS_EP_TX_CSR 5'h04
`define OFS_EP_RX_CSR 5'h08
`define OFS_EOF_RESET 5'h0C
`define OFS_EP_INDEX 5'h10
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define TX_AUTO_BIT 31
`define TX_ISO_BIT 30
`define TX_DIR_BIT 29
`define TX_DMA_EN_BIT 28
`define TX_FORCE_BIT 27
`define TX_DMA_MODE_BIT 26
`define TX_TWEN_BIT 25
`define TX_TOGGLE_BIT 24
`define TX_READY_BIT 16
`define RX_TWEN_BIT 26
`define RX_TOGGLE_BIT 25
`define RX_INCOMP_BIT 24
`define RX_CLR_TGL_BIT 23
`define RX_STALL_FLAG_BIT 22
`define RX_STALL_CTL_BIT 21
`define RX_FLUSH_BIT 20
`define RX_ERR_BIT 19
`define RX_READY_BIT 16
`define OPT_WIDTH_BIT 24
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define LS_EOF_RESET 8'h72
`define FS_EOF_RESET 8'h77
`define HS_EOF_RESET 8'h80
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define LS_EOF_UNIT_NS 1067
`define FS_EOF_UNIT_NS 533300
`define HS_EOF_UNIT_NS 133300
`define LS_EOF_UNIT_CYC ((`LS_EOF_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FS_EOF_UNIT_CYC ((`FS_EOF_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HS_EOF_UNIT_CYC ((`HS_EOF_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: hw/usb_ep_csr_pkg.sv
// Types shared by the endpoint CSR block and its bench
package usb_ep_csr_pkg;
	// ------------------------------------------------------------
	// Per-endpoint control and status state
	// ------------------------------------------------------------
	typedef struct packed {
		logic tx_auto_ready;
		logic iso_tx;
		logic dir_tx;
		logic dma_request_enable;
		logic dma_request_mode;
		logic tx_toggle_write_enable;
		logic tx_toggle;
		logic tx_packet_ready;
		logic [10:0] tx_max_packet_size;
		logic rx_toggle_write_enable;
		logic rx_toggle;
		logic rx_incomplete_flag;
		logic stall_flag;
		logic stall_control;
		logic rx_data_error;
		logic rx_packet_ready;
	} ep_state_s;
	// ------------------------------------------------------------
	// Event word from the link-side engine, one endpoint per cycle
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] ep;
		logic tx_loaded;
		logic [10:0] tx_bytes;
		logic tx_sent;
		logic tx_acked;
		logic rx_packet;
		logic rx_crc_error;
		logic rx_partial;
		logic stall;
		logic nak_limit;
	} link_event_s;
endpackage

// File: hw/usb_endpoint_csr_control.sv
// Endpoint control/status registers with an Avalon-MM slave
// ------------------------------------------------------------
// Notes on behaviour
// - Option word bits 31,30 report amalgamate/split options
// - PHY width option flag always reads zero
// - Bit 29 reads one for big endian
// - Auto-ready sets tx ready on full packet
// - Iso tx only in peripheral mode; host reads zero
// - Direction bit matters only with shared FIFO; O_DMA_REQ follows it with or without shared FIFO
// - DMA requests only while enabled; mode picks type
// - Force toggle flips tx toggle, drops packet
// - Host tx toggle writable only with enable set
// - Host rx toggle writable only with enable set
// - Incomplete flag set by hardware, cleared writing zero
// - Clear-toggle one zeroes rx toggle; zero ignored
// - Stall flag set on stall sent/received
// - Peripheral: bit 21 issues stall handshakes
// - Host: bit 21 requests IN, cleared on ready
// - Flush drops rx packet, clears ready, self-clears
// - Peripheral iso error flag clears with ready
// - Host error flag also marks NAK limit halt
// - Bits 25,24 hold PHY and bus domains reset
// - Low-speed gap counts 1.067 us units
// - Full-speed gap counts 533.3 us units
// - High-speed gap counts 133.3 us units
// - Endpoint select field picks indexed registers
// ------------------------------------------------------------
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "usb_ep_csr_defines.svh"
module usb_endpoint_csr_control #(
	parameter bit AMALGAMATE_OPT = 1'b0,
	parameter bit SPLIT_OPT = 1'b0,
	parameter bit BIG_ENDIAN_OPT = 1'b0,
	parameter bit HB_RX_OPT = 1'b0,
	parameter bit HB_TX_OPT = 1'b0,
	parameter bit DYN_FIFO_OPT = 1'b0,
	parameter bit SOFT_CONN_OPT = 1'b1,
	parameter int unsigned FS_EOF_UNIT_CYC = `FS_EOF_UNIT_CYC,
	parameter int unsigned HS_EOF_UNIT_CYC = `HS_EOF_UNIT_CYC
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RST,
	input wire logic [4:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	input wire logic I_HOST_MODE,
	input wire logic [7:1] I_RX_ISO,
	input wire logic [7:1] I_SHARED_FIFO,
	input wire usb_ep_csr_pkg::link_event_s I_LINK_EVENT,
	output logic [7:1] O_TX_PACKET_READY,
	output logic [7:1] O_RX_PACKET_READY,
	output logic [7:1] O_ISO_TX,
	output logic [7:1] O_DIR_TX,
	output logic [7:1] O_ISSUE_STALL,
	output logic [7:1] O_IN_REQUEST,
	output logic [7:1] O_DMA_REQ,
	output logic [7:1] O_DMA_MODE,
	output logic [7:1] O_TX_TOGGLE,
	output logic [7:1] O_RX_TOGGLE,
	output logic O_TX_FLUSH,
	output logic O_RX_FLUSH,
	output logic [2:0] O_FLUSH_EP,
	output logic O_PHY_DOMAIN_RESET,
	output logic O_BUS_DOMAIN_RESET,
	output logic [23:0] O_LS_EOF_GAP_CYC,
	output logic [23:0] O_FS_EOF_GAP_CYC,
	output logic [23:0] O_HS_EOF_GAP_CYC
);
	localparam int unsigned LS_EOF_UNIT_CYC = `LS_EOF_UNIT_CYC;
	// ------------------------------------------------------------
	// Bus slave: one wait cycle, then answer
	// ------------------------------------------------------------
	// One fixed wait keeps read data on a flop, not on the address mux
	// Trade-off: every access costs two cycles, back to back or not
	logic ack;
	logic [31:0] rdata;
	wire req = I_AVS_READ | I_AVS_WRITE;
	wire wr_fire = I_AVS_WRITE & ack;
	wire a_opt = I_AVS_ADDRESS == `OFS_EP0_OPTION;
	wire a_tx = I_AVS_ADDRESS == `OFS_EP_TX_CSR;
	wire a_rx = I_AVS_ADDRESS == `OFS_EP_RX_CSR;
	wire a_eof = I_AVS_ADDRESS == `OFS_EOF_RESET;
	wire a_idx = I_AVS_ADDRESS == `OFS_EP_INDEX;
	wire [31:0] be_mask = {{8{I_AVS_BYTEENABLE[3]}}, {8{I_AVS_BYTEENABLE[2]}},
		{8{I_AVS_BYTEENABLE[1]}}, {8{I_AVS_BYTEENABLE[0]}}};
	assign O_AVS_WAITREQUEST = req & ~ack;
	assign O_AVS_READDATA = rdata;

	// ------------------------------------------------------------
	// Shared registers
	// ------------------------------------------------------------
	logic [3:0] sel_ep;
	logic phy_rst;
	logic bus_rst;
	logic [7:0] ls_gap;
	logic [7:0] fs_gap;
	logic [7:0] hs_gap;
	// Seven copies in flops; too few words for a RAM to pay off
	usb_ep_csr_pkg::ep_state_s st [1:7];

	// Endpoint 0 and numbers above 7 select nothing
	wire sel_ok = ~sel_ep[3] & (sel_ep[2:0] != 3'h0);
	wire [2:0] sel = sel_ep[2:0];
	wire usb_ep_csr_pkg::ep_state_s cur = sel_ok ? st[sel] : '0;
	wire cur_iso_rx = sel_ok & I_RX_ISO[sel];
	wire cur_err = I_HOST_MODE ? cur.rx_data_error : cur.rx_data_error & cur_iso_rx;

	wire [31:0] opt_rd = {AMALGAMATE_OPT, SPLIT_OPT, BIG_ENDIAN_OPT, HB_RX_OPT,
		HB_TX_OPT, DYN_FIFO_OPT, SOFT_CONN_OPT, 1'b0, 24'h0};
	wire [31:0] tx_rd = {cur.tx_auto_ready, cur.iso_tx & ~I_HOST_MODE, cur.dir_tx,
		cur.dma_request_enable, 1'b0, cur.dma_request_mode, cur.tx_toggle_write_enable,
		cur.tx_toggle, 7'h0, cur.tx_packet_ready, 5'h0, cur.tx_max_packet_size};
	wire [31:0] rx_rd = {5'h0, cur.rx_toggle_write_enable, cur.rx_toggle,
		cur.rx_incomplete_flag & cur_iso_rx, 1'b0, cur.stall_flag, cur.stall_control,
		1'b0, cur_err, 2'h0, cur.rx_packet_ready, 16'h0};
	wire [31:0] eof_rd = {6'h0, phy_rst, bus_rst, ls_gap, fs_gap, hs_gap};
	wire [31:0] idx_rd = {12'h0, sel_ep, 16'h0};
	wire [31:0] reg_rd = a_opt ? opt_rd : a_tx ? tx_rd : a_rx ? rx_rd :
		a_eof ? eof_rd : a_idx ? idx_rd : 32'h0;
	// Disabled byte lanes keep the present view, so W0C flags survive
	wire [31:0] wd = (reg_rd & ~be_mask) | (I_AVS_WRITEDATA & be_mask);

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			ack <= 1'b0;
			rdata <= 32'h0;
		end else begin
			ack <= req & ~ack;
			if (I_AVS_READ & ~ack) begin
				rdata <= reg_rd;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			sel_ep <= 4'h0;
			phy_rst <= 1'b0;
			bus_rst <= 1'b0;
			ls_gap <= `LS_EOF_RESET;
			fs_gap <= `FS_EOF_RESET;
			hs_gap <= `HS_EOF_RESET;
		end else if (wr_fire & a_idx) begin
			sel_ep <= wd[19:16];
		end else if (wr_fire & a_eof) begin
			phy_rst <= wd[25];
			bus_rst <= wd[24];
			ls_gap <= wd[23:16];
			fs_gap <= wd[15:8];
			hs_gap <= wd[7:0];
		end
	end

	// ------------------------------------------------------------
	// Flush pulses toward the FIFO logic
	// ------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			O_TX_FLUSH <= 1'b0;
			O_RX_FLUSH <= 1'b0;
			O_FLUSH_EP <= 3'h0;
		end else begin
			O_TX_FLUSH <= wr_fire & a_tx & sel_ok & wd[`TX_FORCE_BIT];
			O_RX_FLUSH <= wr_fire & a_rx & sel_ok & wd[`RX_FLUSH_BIT];
			O_FLUSH_EP <= sel;
		end
	end

	// ------------------------------------------------------------
	// Soft resets and end-of-frame gaps
	// ------------------------------------------------------------
	assign O_PHY_DOMAIN_RESET = phy_rst;
	assign O_BUS_DOMAIN_RESET = bus_rst;
	// Gaps leave as cycle counts so the frame timer needs no multiplier
	assign O_LS_EOF_GAP_CYC = 24'(ls_gap * LS_EOF_UNIT_CYC);
	assign O_FS_EOF_GAP_CYC = 24'(fs_gap * FS_EOF_UNIT_CYC);
	assign O_HS_EOF_GAP_CYC = 24'(hs_gap * HS_EOF_UNIT_CYC);

	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);

	// ------------------------------------------------------------
	// Per-endpoint state
	// ------------------------------------------------------------
	genvar i;
	generate
		for (i = 1; i <= 7; i++) begin : g_ep
			usb_ep_csr_pkg::ep_state_s next_st;
			usb_ep_csr_pkg::ep_state_s s;
			wire hit_tx = wr_fire & a_tx & sel_ok & (sel == i);
			wire hit_rx = wr_fire & a_rx & sel_ok & (sel == i);
			wire ev = I_LINK_EVENT.ep == i;
			wire ev_tx = ev & (I_LINK_EVENT.tx_sent | I_LINK_EVENT.tx_loaded);
			wire ev_rx = ev & I_LINK_EVENT.rx_packet;
			wire host = I_HOST_MODE;
			assign s = st[i];

			always_comb begin
				next_st = s;
				if (hit_tx) begin
					next_st.tx_auto_ready = wd[`TX_AUTO_BIT];
					next_st.iso_tx = wd[`TX_ISO_BIT];
					next_st.dir_tx = wd[`TX_DIR_BIT];
					next_st.dma_request_enable = wd[`TX_DMA_EN_BIT];
					next_st.dma_request_mode = wd[`TX_DMA_MODE_BIT];
					next_st.tx_toggle_write_enable = wd[`TX_TWEN_BIT];
					next_st.tx_max_packet_size = wd[10:0];
					if (host & wd[`TX_TWEN_BIT]) begin
						next_st.tx_toggle = wd[`TX_TOGGLE_BIT];
					end
					if (wd[`TX_READY_BIT]) begin
						next_st.tx_packet_ready = 1'b1;
					end
					if (wd[`TX_FORCE_BIT]) begin
						next_st.tx_toggle = ~s.tx_toggle;
						next_st.tx_packet_ready = 1'b0;
					end
				end
				if (hit_rx) begin
					next_st.rx_toggle_write_enable = wd[`RX_TWEN_BIT];
					if (host & wd[`RX_TWEN_BIT]) begin
						next_st.rx_toggle = wd[`RX_TOGGLE_BIT];
					end
					if (wd[`RX_CLR_TGL_BIT]) begin
						next_st.rx_toggle = 1'b0;
					end
					next_st.rx_incomplete_flag = s.rx_incomplete_flag & wd[`RX_INCOMP_BIT];
					next_st.stall_flag = s.stall_flag & wd[`RX_STALL_FLAG_BIT];
					next_st.stall_control = wd[`RX_STALL_CTL_BIT];
					next_st.rx_packet_ready = s.rx_packet_ready & wd[`RX_READY_BIT];
					if (wd[`RX_FLUSH_BIT]) begin
						next_st.rx_packet_ready = 1'b0;
					end
					if (host) begin
						next_st.rx_data_error = s.rx_data_error & wd[`RX_ERR_BIT];
					end else if (~next_st.rx_packet_ready) begin
						next_st.rx_data_error = 1'b0;
					end
				end
				// Hardware events come last so a hardware set or clear beats a same-cycle write
				if (ev & I_LINK_EVENT.tx_loaded & s.tx_auto_ready &
					(I_LINK_EVENT.tx_bytes == s.tx_max_packet_size)) begin
					next_st.tx_packet_ready = 1'b1;
				end
				if (ev & I_LINK_EVENT.tx_sent) begin
					next_st.tx_packet_ready = 1'b0;
					if (I_LINK_EVENT.tx_acked) begin
						next_st.tx_toggle = ~next_st.tx_toggle;
					end
				end
				if (ev_rx) begin
					next_st.rx_packet_ready = 1'b1;
					next_st.rx_toggle = ~next_st.rx_toggle;
					next_st.rx_data_error = next_st.rx_data_error | I_LINK_EVENT.rx_crc_error;
					next_st.rx_incomplete_flag = next_st.rx_incomplete_flag |
						I_LINK_EVENT.rx_partial;
					if (host) begin
						next_st.stall_control = 1'b0;
					end
				end
				if (ev & I_LINK_EVENT.stall) begin
					next_st.stall_flag = 1'b1;
				end
				if (ev & I_LINK_EVENT.nak_limit & host) begin
					next_st.rx_data_error = 1'b1;
				end
			end

			always_ff @(posedge I_CORE_CLK) begin
				if (I_RST) begin
					st[i] <= '0;
				end else begin
					st[i] <= next_st;
				end
			end

			assign O_TX_PACKET_READY[i] = s.tx_packet_ready;
			assign O_RX_PACKET_READY[i] = s.rx_packet_ready;
			assign O_ISO_TX[i] = s.iso_tx & ~host;
			assign O_DIR_TX[i] = s.dir_tx & I_SHARED_FIFO[i];
			assign O_ISSUE_STALL[i] = s.stall_control & ~host;
			assign O_IN_REQUEST[i] = s.stall_control & host;
			// Request follows the FIFO side that the direction selects
			assign O_DMA_REQ[i] = s.dma_request_enable &
				(s.dir_tx ? ~s.tx_packet_ready : s.rx_packet_ready);
			assign O_DMA_MODE[i] = s.dma_request_mode;
			assign O_TX_TOGGLE[i] = s.tx_toggle;
			assign O_RX_TOGGLE[i] = s.rx_toggle;

			// ------------------------------------------------------------
			// Endpoint checks; link events masked where they race a write
			// ------------------------------------------------------------
			sequence s_flush_write;
				hit_rx & wd[`RX_FLUSH_BIT] & ~ev_rx;
			endsequence
			sequence s_flush_done;
				~s.rx_packet_ready & O_RX_FLUSH & (O_FLUSH_EP == i);
			endsequence

			a_auto_ready_set: assert property (
				ev & I_LINK_EVENT.tx_loaded & ~I_LINK_EVENT.tx_sent & s.tx_auto_ready &
				(I_LINK_EVENT.tx_bytes == s.tx_max_packet_size) |=> s.tx_packet_ready)
				else $error("auto ready not set");
			a_iso_host_zero: assert property (
				hit_tx & wd[`TX_ISO_BIT] |=> O_ISO_TX[i] == ~host)
				else $error("iso tx active in host mode");
			a_dma_req_gate: assert property (
				O_DMA_REQ[i] |-> s.dma_request_enable)
				else $error("dma request while disabled");
			a_force_toggle_flip: assert property (
				hit_tx & wd[`TX_FORCE_BIT] & ~ev_tx |=>
				(s.tx_toggle != $past(s.tx_toggle)) && ~s.tx_packet_ready)
				else $error("force toggle failed");
			a_tx_toggle_lock: assert property (
				hit_tx & ~wd[`TX_TWEN_BIT] & ~wd[`TX_FORCE_BIT] & ~ev_tx |=> $stable(s.tx_toggle))
				else $error("tx toggle written without enable");
			a_clear_toggle_zero: assert property (
				hit_rx & wd[`RX_CLR_TGL_BIT] & ~ev_rx |=> ~s.rx_toggle)
				else $error("clear toggle failed");
			a_stall_flag_set: assert property (
				ev & I_LINK_EVENT.stall |=> s.stall_flag [*1] ##0 ~hit_rx or s.stall_flag)
				else $error("stall flag not set");
			a_in_request_clear: assert property (
				host & ev_rx |=> ~O_IN_REQUEST[i])
				else $error("in request not cleared");
			a_flush_rx_packet: assert property (s_flush_write |=> s_flush_done)
				else $error("flush did not clear packet");
			a_nak_limit_err: assert property (
				host & ev & I_LINK_EVENT.nak_limit |=> s.rx_data_error)
				else $error("nak limit not flagged");
			a_dir_shared_only: assert property (
				hit_tx & wd[`TX_DIR_BIT] |=> O_DIR_TX[i] == I_SHARED_FIFO[i])
				else $error("direction not gated by shared fifo");
			a_rx_toggle_lock: assert property (
				hit_rx & ~wd[`RX_TWEN_BIT] & ~wd[`RX_CLR_TGL_BIT] & ~ev_rx |=>
				$stable(s.rx_toggle))
				else $error("rx toggle written without enable");
			a_rx_toggle_write: assert property (
				host & hit_rx & wd[`RX_TWEN_BIT] & ~wd[`RX_CLR_TGL_BIT] & ~ev_rx |=>
				s.rx_toggle == $past(wd[`RX_TOGGLE_BIT]))
				else $error("rx toggle write lost");
			a_incomplete_set: assert property (
				ev_rx & I_LINK_EVENT.rx_partial |=> s.rx_incomplete_flag)
				else $error("incomplete flag not set");
			a_stall_ctl_mode: assert property (
				hit_rx & wd[`RX_STALL_CTL_BIT] & ~ev_rx |=>
				O_ISSUE_STALL[i] == ~host && O_IN_REQUEST[i] == host)
				else $error("stall control not routed by mode");
			a_error_clear_ready: assert property (
				~host & hit_rx & ~wd[`RX_READY_BIT] & ~ev_rx |=> ~s.rx_data_error)
				else $error("error flag kept after ready cleared");
		end
	endgenerate

	// ------------------------------------------------------------
	// Bus and shared register checks
	// ------------------------------------------------------------
	a_bus_one_wait: assert property (
		req & O_AVS_WAITREQUEST |=> ~O_AVS_WAITREQUEST ##1 (~req | O_AVS_WAITREQUEST))
		else $error("bus answer not in one cycle");
	a_width_flag_zero: assert property (
		I_AVS_READ & a_opt & O_AVS_WAITREQUEST |=> ~O_AVS_READDATA[`OPT_WIDTH_BIT])
		else $error("phy width flag not zero");
	a_domain_reset_bits: assert property (
		wr_fire & a_eof |=> O_PHY_DOMAIN_RESET == $past(wd[25]) &&
		O_BUS_DOMAIN_RESET == $past(wd[24]))
		else $error("soft reset bits wrong");
	a_ls_gap_cycles: assert property (
		O_LS_EOF_GAP_CYC == 24'(ls_gap * 43))
		else $error("low speed gap count wrong");
	a_index_select: assert property (
		wr_fire & a_idx |=> sel_ep == $past(wd[19:16]))
		else $error("endpoint select not written");
	a_flush_one_pulse: assert property (
		O_RX_FLUSH |=> ~O_RX_FLUSH)
		else $error("flush pulse longer than one cycle");
endmodule

// File: dv/usb_link_engine_model.sv
// Link-side engine model that reports endpoint events to the CSR block
`timescale 1ns/100ps
module usb_link_engine_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_go,
	input wire logic [2:0] i_kind,
	input wire logic [2:0] i_ep,
	input wire logic [10:0] i_bytes,
	input wire logic [1:0] i_lag,
	output usb_ep_csr_pkg::link_event_s o_event,
	output logic o_busy
);
	logic [1:0] wait_cnt;
	logic [2:0] kind;
	logic [2:0] ep;
	logic [10:0] bytes;
	usb_ep_csr_pkg::link_event_s next_event;
	// ------------------------------------------------------------
	// Event builder
	// ------------------------------------------------------------
	always_comb begin
		next_event = '0;
		next_event.ep = ep;
		case (kind)
			3'd0: begin
				next_event.tx_loaded = 1'b1;
				next_event.tx_bytes = bytes;
			end
			3'd1: begin
				next_event.tx_sent = 1'b1;
				next_event.tx_acked = 1'b1;
			end
			3'd2: next_event.rx_packet = 1'b1;
			3'd3: begin
				next_event.rx_packet = 1'b1;
				next_event.rx_crc_error = 1'b1;
			end
			3'd4: begin
				next_event.rx_packet = 1'b1;
				next_event.rx_partial = 1'b1;
			end
			3'd5: next_event.stall = 1'b1;
			default: next_event.nak_limit = 1'b1;
		endcase
	end
	// ------------------------------------------------------------
	// Sequencer; idle fields keep moving so stale data never looks valid
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_busy <= 1'b0;
			wait_cnt <= 2'h0;
			kind <= 3'h0;
			ep <= 3'h0;
			bytes <= 11'h000;
			o_event <= '0;
		end else if (o_busy && wait_cnt != 2'h0) begin
			wait_cnt <= wait_cnt - 2'h1;
			o_event <= '{ep: ~o_event.ep, tx_bytes: ~o_event.tx_bytes, default: 1'b0};
		end else if (o_busy) begin
			o_busy <= 1'b0;
			o_event <= next_event;
		end else begin
			o_busy <= i_go;
			wait_cnt <= i_lag;
			kind <= i_kind;
			ep <= i_ep;
			bytes <= i_bytes;
			o_event <= '{ep: ~o_event.ep, tx_bytes: ~o_event.tx_bytes, default: 1'b0};
		end
	end
endmodule

// File: dv/usb_endpoint_csr_control_tb_top.sv
// Self-checking bench for the endpoint CSR block
`timescale 1ns/100ps
`include "usb_ep_csr_defines.svh"
module usb_endpoint_csr_control_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] adr = 5'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic waitreq;
	logic host = 1'b0;
	logic [7:1] rx_iso = 7'h00;
	logic [7:1] shared = 7'h02;
	usb_ep_csr_pkg::link_event_s lev;
	logic go = 1'b0;
	logic [2:0] kind = 3'h0;
	logic [10:0] nbytes = 11'h000;
	logic [1:0] lag = 2'h0;
	logic busy;
	logic [7:1] txr, rxr, iso, dir, stl, inq, dreq, dmode, ttg, rtg;
	logic txf, rxf, phr, bur;
	logic [2:0] fep;
	logic [23:0] lsg, fsg, hsg;
	logic [31:0] got;
	logic [3:0] ben = 4'hF;
	logic [2:0] fl_ep = 3'h0;
	int tx_fl = 0;
	int rx_fl = 0;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	// ------------------------------------------------------------
	// Instances
	// ------------------------------------------------------------
	usb_endpoint_csr_control #(.AMALGAMATE_OPT(1'b1), .BIG_ENDIAN_OPT(1'b1),
		.FS_EOF_UNIT_CYC(4), .HS_EOF_UNIT_CYC(4)) i_usb_endpoint_csr_control (
		.I_CORE_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd_en),
		.I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(ben),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .I_HOST_MODE(host),
		.I_RX_ISO(rx_iso), .I_SHARED_FIFO(shared), .I_LINK_EVENT(lev),
		.O_TX_PACKET_READY(txr), .O_RX_PACKET_READY(rxr), .O_ISO_TX(iso), .O_DIR_TX(dir),
		.O_ISSUE_STALL(stl), .O_IN_REQUEST(inq), .O_DMA_REQ(dreq), .O_DMA_MODE(dmode),
		.O_TX_TOGGLE(ttg), .O_RX_TOGGLE(rtg), .O_TX_FLUSH(txf), .O_RX_FLUSH(rxf),
		.O_FLUSH_EP(fep), .O_PHY_DOMAIN_RESET(phr), .O_BUS_DOMAIN_RESET(bur),
		.O_LS_EOF_GAP_CYC(lsg), .O_FS_EOF_GAP_CYC(fsg), .O_HS_EOF_GAP_CYC(hsg));
	usb_link_engine_model i_usb_link_engine_model (.i_clk(clk), .i_rst(rst), .i_go(go),
		.i_kind(kind), .i_ep(3'd2), .i_bytes(nbytes), .i_lag(lag), .o_event(lev), .o_busy(busy));
	// ------------------------------------------------------------
	// Clock, watchdog, shared tasks
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;
	// Counts flush pulses so a one-cycle pulse is never missed between checks
	always @(posedge clk) begin
		if (txf | rxf) begin
			fl_ep <= fep;
		end
		tx_fl <= tx_fl + int'(txf);
		rx_fl <= rx_fl + int'(rxf);
	end
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			err_total = err_total + 1;
			results();
		end
	end
	task automatic results();
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Waits for waitrequest low, no fixed latency assumed
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		adr <= a;
		wdata <= d;
		rd_en <= ~w;
		wr_en <= w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		chk({31'h0, waitreq}, 32'h0);
		got = rdata;
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(got & m, e);
	endtask
	task automatic ev(input logic [2:0] k, input logic [10:0] b, input logic [1:0] l);
		int n;
		n = 0;
		kind <= k;
		nbytes <= b;
		lag <= l;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (busy !== 1'b0 && n < 20);
		repeat (2) @(posedge clk);
	endtask
	task automatic flush_seen(input logic tx);
		repeat (2) @(posedge clk);
		chk({24'h0, 5'(tx ? tx_fl : rx_fl), fl_ep}, 32'hA);
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_static();
		rd(`OFS_EP0_OPTION, 32'hFFFF_FFFF, 32'hA200_0000);
		rd(`OFS_EOF_RESET, 32'hFFFF_FFFF, 32'h0072_7780);
		chk({lsg, fsg[7:0]}, {24'(32'h72 * 43), 8'(32'h77 * 4)});
		chk({8'h0, hsg}, 32'h80 * 4);
		rd(`OFS_EP_TX_CSR, 32'hFFFF_FFFF, 32'h0);
		wr(`OFS_EP_INDEX, 32'h0008_0000);
		wr(`OFS_EP_TX_CSR, 32'hFFFF_FFFF);
		rd(`OFS_EP_TX_CSR, 32'hFFFF_FFFF, 32'h0);
		wr(5'h14, 32'hFFFF_FFFF);
		rd(5'h14, 32'hFFFF_FFFF, 32'h0);
		wr(`OFS_EOF_RESET, 32'h0300_0102);
		chk({6'h0, phr, bur, lsg}, {8'h3, 24'h0});
		chk({8'h0, fsg}, 32'h4);
		chk({8'h0, hsg}, 32'h8);
		wr(`OFS_EOF_RESET, 32'h0072_7780);
		chk({30'h0, phr, bur}, 32'h0);
		ben <= 4'h2;
		wr(`OFS_EOF_RESET, 32'hFFFF_55FF);
		ben <= 4'hF;
		rd(`OFS_EOF_RESET, 32'hFFFF_FFFF, 32'h0072_5580);
		chk({8'h0, fsg}, 32'h154);
	endtask
	task automatic t_tx();
		wr(`OFS_EP_INDEX, 32'h0002_0000);
		wr(`OFS_EP_TX_CSR, 32'h8000_0008);
		ev(3'd0, 11'd8, 2'd3);
		chk({31'h0, txr[2]}, 32'h1);
		ev(3'd1, 11'd0, 2'd0);
		ev(3'd0, 11'd4, 2'd0);
		chk({31'h0, txr[2]}, 32'h0);
		wr(`OFS_EP_TX_CSR, 32'h0000_0008);
		ev(3'd0, 11'd8, 2'd1);
		chk({31'h0, txr[2]}, 32'h0);
		wr(`OFS_EP_TX_CSR, 32'h0001_0008);
		wr(`OFS_EP_TX_CSR, 32'h7400_0000);
		chk({28'h0, iso[2], dir[2], dmode[2], dreq[2]}, 32'hE);
		ev(3'd1, 11'd0, 2'd2);
		chk({31'h0, dreq[2]}, 32'h1);
		host <= 1'b1;
		shared <= 7'h00;
		@(posedge clk);
		@(posedge clk);
		chk({30'h0, iso[2], dir[2]}, 32'h0);
		rd(`OFS_EP_TX_CSR, 32'h4000_0000, 32'h0);
		shared <= 7'h02;
		wr(`OFS_EP_TX_CSR, 32'h6400_0000);
		chk({31'h0, dreq[2]}, 32'h0);
		wr(`OFS_EP_TX_CSR, 32'h0300_0000);
		rd(`OFS_EP_TX_CSR, 32'h0100_0000, 32'h0100_0000);
		wr(`OFS_EP_TX_CSR, 32'h0000_0000);
		chk({31'h0, ttg[2]}, 32'h1);
		wr(`OFS_EP_TX_CSR, 32'h0800_0000);
		flush_seen(1'b1);
		chk({31'h0, ttg[2]}, 32'h0);
	endtask
	task automatic t_rx();
		rx_iso <= 7'h02;
		wr(`OFS_EP_RX_CSR, 32'h0600_0000);
		wr(`OFS_EP_RX_CSR, 32'h0000_0000);
		chk({31'h0, rtg[2]}, 32'h1);
		wr(`OFS_EP_RX_CSR, 32'h0080_0000);
		chk({31'h0, rtg[2]}, 32'h0);
		wr(`OFS_EP_RX_CSR, 32'h0020_0000);
		chk({30'h0, inq[2], stl[2]}, 32'h2);
		ev(3'd2, 11'd0, 2'd3);
		chk({30'h0, inq[2], rxr[2]}, 32'h1);
		ev(3'd4, 11'd0, 2'd0);
		ev(3'd5, 11'd0, 2'd1);
		ev(3'd6, 11'd0, 2'd0);
		rd(`OFS_EP_RX_CSR, 32'h0149_0000, 32'h0149_0000);
		wr(`OFS_EP_RX_CSR, 32'h0009_0000);
		rd(`OFS_EP_RX_CSR, 32'h0149_0000, 32'h0009_0000);
		wr(`OFS_EP_RX_CSR, 32'h0019_0000);
		flush_seen(1'b0);
		rd(`OFS_EP_RX_CSR, 32'h0011_0000, 32'h0);
		rx_iso <= 7'h00;
		ev(3'd4, 11'd0, 2'd0);
		rd(`OFS_EP_RX_CSR, 32'h0100_0000, 32'h0);
		host <= 1'b0;
		wr(`OFS_EP_RX_CSR, 32'h0020_0000);
		chk({30'h0, inq[2], stl[2]}, 32'h1);
		wr(`OFS_EP_RX_CSR, 32'h0000_0000);
		chk({31'h0, stl[2]}, 32'h0);
		rx_iso <= 7'h02;
		ev(3'd3, 11'd0, 2'd2);
		rd(`OFS_EP_RX_CSR, 32'h0009_0000, 32'h0009_0000);
		wr(`OFS_EP_RX_CSR, 32'h0008_0000);
		rd(`OFS_EP_RX_CSR, 32'h0009_0000, 32'h0);
		rx_iso <= 7'h00;
		ev(3'd3, 11'd0, 2'd0);
		rd(`OFS_EP_RX_CSR, 32'h0009_0000, 32'h0001_0000);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_static();
		t_tx();
		t_rx();
		results();
	end
endmodule
